// file: src/i2cc_pkg.sv
/*
 holds the constants, register layout and carrier structs of the i2c control/status block.
 assumes a byte wide register port and a bus engine on the same clock.
*/
// Functional notes
// - wait mode: run unchanged, events wake cpu
// - halt: inactive, no ack, registers frozen
// - one irq when enabled and unmasked
// - reserved control and status bits read zero
// - disabled: clear all but stop, busy; release lines
// - first enabling write sets only enable and stop
// - general call 00h acked, 01h ignored
// - start bit: start request, cleared when sent
// - ack enable drives acknowledge, cleared on disable
// - master stop request, cleared once sent
// - slave stop releases lines after byte
// - irq enable cleared on disable
// - hold scl low while start, byte done, address match or post-address flags pending
// - event flag follows any pending event
// - transmitted flag valid with byte done
// - busy tracks bus start and stop
// - tx byte done, cleared by read+write
// - rx byte done, cleared by read+read
// - address match flag, cleared by read
// - master flag set by start, cleared
// - start sent flag, cleared by read+write
// - secondary flags cleared by read except general call, all by disable
`default_nettype none
package i2cc_pkg;
   // ==========================================
   // register offsets
   localparam logic [3:0] OFS_DATA = 4'h0;
   localparam logic [3:0] OFS_SEC  = 4'h1;
   localparam logic [3:0] OFS_PRI  = 4'h2;
   localparam logic [3:0] OFS_CTRL = 4'h3;
   // ==========================================
   // control register bit positions
   localparam int CR_PE   = 5;
   localparam int CR_GC   = 4;
   localparam int CR_STA  = 3;
   localparam int CR_ACK  = 2;
   localparam int CR_STOP = 1;
   localparam int CR_ITE  = 0;
   // ==========================================
   // primary status bit positions
   localparam int PS_EVF  = 7;
   localparam int PS_TRA  = 5;
   localparam int PS_BUSY = 4;
   localparam int PS_BTF  = 3;
   localparam int PS_ADM  = 2;
   localparam int PS_MST  = 1;
   localparam int PS_SB   = 0;
   // ==========================================
   // secondary status bit positions
   localparam int SS_AF   = 4;
   localparam int SS_STOP = 3;
   localparam int SS_ARB  = 2;
   localparam int SS_BUS_ERROR_FLAG = 1;
   localparam int SS_GC   = 0;
   // ==========================================
   // special addresses
   localparam logic [7:0] GC_ADDR   = 8'h00;
   localparam logic [7:0] IGNR_ADDR = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ==========================================
   // carriers
   typedef struct packed {
      logic periph_enable;
      logic general_call_enable;
      logic start;
      logic ack_enable;
      logic stop;
      logic irq_enable;
   } i2cc_ctrl_s;
   typedef struct packed {
      logic ack_failure_flag;
      logic stop_seen_flag;
      logic arb_lost_flag;
      logic bus_error_flag;
      logic general_call_flag;
   } i2cc_sec_s;
   typedef struct packed {
      logic byte_done;
      logic byte_tx;
      logic addr_rx;
      logic start_sent;
      logic stop_sent;
      logic addr_sent;
      logic ack_fail;
      logic arb_lost;
   } i2cc_ev_s;
endpackage
`default_nettype wire

// file: src/i2cc_ctrl.sv
/*
 control and primary/secondary status logic of a multi-master i2c interface.
 assumes a bus engine on ref_clk that reports events as one-cycle pulses,
 and open-drain scl/sda pins resolved outside from the enables.
*/
`default_nettype none
module i2cc_ctrl
   import i2cc_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire logic              cpu_halt,
   input  wire logic              cpu_gmask,
   output logic                   irq,
   output logic                   wake_req,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe_n,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_n,
   input  wire i2cc_ev_s          eng_ev,
   input  wire logic [7:0]        eng_addr_byte,
   input  wire logic [7:0]        eng_rx_data,
   input  wire logic              eng_byte_active,
   input  wire logic              eng_scl_low,
   input  wire logic              eng_sda_low,
   input  wire logic [7:0]        own_addr,
   output logic                   start_req,
   output logic                   stop_req,
   output logic                   ack_en,
   output logic                   gc_en,
   output logic                   pins_claimed,
   output logic      [7:0]        tx_data,
   output logic                   tx_load
);
   // ==========================================
   // elaboration checks
   generate
      if (ADDR_W < 2) begin : g_chk
         $error("ADDR_W must be at least 2");
      end
   endgenerate

   // ==========================================
   // state
   typedef struct packed {
      i2cc_ctrl_s ctrl;
      i2cc_sec_s  sec;
      logic       event_flag;
      logic       transmitted_flag;
      logic       busy;
      logic       byte_done_flag;
      logic       addr_matched_flag;
      logic       master;
      logic       sb;
      logic       post_addr;
      logic       sr1_seen;
      logic       release_l;
      logic       scl_m1;
      logic       scl_m2;
      logic       scl_p;
      logic       sda_m1;
      logic       sda_m2;
      logic       sda_p;
      logic [7:0] rdata;
      logic [7:0] tx_data;
      logic       tx_load;
      logic       scl_oe_n;
      logic       sda_oe_n;
      logic       irq;
      logic       wake;
      logic       start_req;
      logic       stop_req;
      logic       ack_en;
      logic       gc_en;
      logic       claimed;
   } i2cc_state_s;

   i2cc_state_s q;
   i2cc_state_s d;

   logic       start_det;
   logic       stop_det;
   logic       sel_data;
   logic       sel_sec;
   logic       sel_pri;
   logic       sel_ctrl;
   logic       match_own;
   logic       match_gc;
   logic       stretch;
   logic       drive_ok;
   logic [7:0] pri_rd;
   logic [7:0] sec_rd;
   logic [7:0] ctrl_rd;

   // ==========================================
   // register read views, reserved bits zero
   always_comb begin
      pri_rd           = BYTE_ZERO;
      pri_rd[PS_EVF]   = q.event_flag;
      pri_rd[PS_TRA]   = q.transmitted_flag;
      pri_rd[PS_BUSY]  = q.busy;
      pri_rd[PS_BTF]   = q.byte_done_flag;
      pri_rd[PS_ADM]   = q.addr_matched_flag;
      pri_rd[PS_MST]   = q.master;
      pri_rd[PS_SB]    = q.sb;
      sec_rd           = BYTE_ZERO;
      sec_rd[SS_AF]    = q.sec.ack_failure_flag;
      sec_rd[SS_STOP]  = q.sec.stop_seen_flag;
      sec_rd[SS_ARB]   = q.sec.arb_lost_flag;
      sec_rd[SS_BUS_ERROR_FLAG]  = q.sec.bus_error_flag;
      sec_rd[SS_GC]    = q.sec.general_call_flag;
      ctrl_rd          = BYTE_ZERO;
      ctrl_rd[CR_PE]   = q.ctrl.periph_enable;
      ctrl_rd[CR_GC]   = q.ctrl.general_call_enable;
      ctrl_rd[CR_STA]  = q.ctrl.start;
      ctrl_rd[CR_ACK]  = q.ctrl.ack_enable;
      ctrl_rd[CR_STOP] = q.ctrl.stop;
      ctrl_rd[CR_ITE]  = q.ctrl.irq_enable;
   end

   // ==========================================
   // decode and bus condition detection
   assign sel_data  = (reg_addr == ADDR_W'(OFS_DATA));
   assign sel_sec   = (reg_addr == ADDR_W'(OFS_SEC));
   assign sel_pri   = (reg_addr == ADDR_W'(OFS_PRI));
   assign sel_ctrl  = (reg_addr == ADDR_W'(OFS_CTRL));
   // the edge detector reads only the second stage and its delayed copy
   assign start_det = q.scl_m2 & q.scl_p & q.sda_p & ~q.sda_m2;
   assign stop_det  = q.scl_m2 & q.scl_p & ~q.sda_p & q.sda_m2;
   // the direction bit is a don't care for the own address
   assign match_own = (eng_addr_byte[7:1] == own_addr[7:1]) && (eng_addr_byte != IGNR_ADDR);
   assign match_gc  = (eng_addr_byte == GC_ADDR) && q.ctrl.general_call_enable;

   // ==========================================
   // next state
   always_comb begin
      d         = q;
      d.tx_load = 1'b0;
      d.scl_m1  = scl_i;
      d.scl_m2  = q.scl_m1;
      d.scl_p   = q.scl_m2;
      d.sda_m1  = sda_i;
      d.sda_m2  = q.sda_m1;
      d.sda_p   = q.sda_m2;
      // halt freezes the state registers; the pin samplers and the registered outputs keep running
      if (!cpu_halt) begin
         // busy tracks the bus whatever the enable
         if (start_det) begin
            d.busy = 1'b1;
         end else if (stop_det) begin
            d.busy = 1'b0;
         end
         // a released slave stays off both lines until the next start, so a
         // stale byte-done cannot pull scl low again in the middle of someone else's frame
         if (start_det) begin
            d.release_l = 1'b0;
         end
         // ---- software side: reads and clears
         if (reg_rd) begin
            if (sel_data) begin
               d.rdata = eng_rx_data;
            end else if (sel_sec) begin
               d.rdata = sec_rd;
            end else if (sel_pri) begin
               d.rdata = pri_rd;
            end else if (sel_ctrl) begin
               d.rdata = ctrl_rd;
            end else begin
               d.rdata = BYTE_ZERO;
            end
            if (sel_pri) begin
               d.sr1_seen = 1'b1;
               d.addr_matched_flag     = 1'b0;
            end
            if (sel_sec) begin
               d.sec.ack_failure_flag = 1'b0;
               d.sec.stop_seen_flag   = 1'b0;
               d.sec.arb_lost_flag    = 1'b0;
               d.sec.bus_error_flag   = 1'b0;
            end
         end
         // a data access finishes a byte only after a status read
         if ((reg_rd || reg_wr) && sel_data && q.sr1_seen) begin
            d.byte_done_flag      = 1'b0;
            d.transmitted_flag      = 1'b0;
            d.sb       = 1'b0;
            d.sr1_seen = 1'b0;
         end
         if (reg_wr && sel_data) begin
            d.tx_data = reg_wdata;
            d.tx_load = q.ctrl.periph_enable;
         end
         if (reg_wr && sel_ctrl) begin
            if (!q.ctrl.periph_enable) begin
               // the first enabling write touches nothing but the enable and the stop bit
               d.ctrl.periph_enable = reg_wdata[CR_PE];
               d.ctrl.stop          = reg_wdata[CR_STOP];
            end else begin
               d.ctrl.periph_enable       = reg_wdata[CR_PE];
               d.ctrl.general_call_enable = reg_wdata[CR_GC];
               d.ctrl.start               = reg_wdata[CR_STA];
               d.ctrl.ack_enable          = reg_wdata[CR_ACK];
               d.ctrl.stop                = reg_wdata[CR_STOP];
               d.ctrl.irq_enable          = reg_wdata[CR_ITE];
               if (reg_wdata[CR_STA] && !q.busy) begin
                  d.master = 1'b1;
               end
               if (q.sr1_seen) begin
                  d.post_addr = 1'b0;
                  d.sr1_seen  = 1'b0;
               end
            end
         end
         // ---- bus side: clears first, so that a set in the same cycle wins; the slave-stop release clears last
         if (q.ctrl.periph_enable) begin
            if (stop_det) begin
               d.master                = 1'b0;
               d.transmitted_flag                   = 1'b0;
               d.sec.general_call_flag = 1'b0;
               if (!q.master) begin
                  d.sec.stop_seen_flag = 1'b1;
               end
            end
            if ((start_det || stop_det) && eng_byte_active) begin
               d.sec.bus_error_flag = 1'b1;
            end
            if (eng_ev.arb_lost) begin
               d.sec.arb_lost_flag = 1'b1;
               d.master            = 1'b0;
               d.transmitted_flag               = 1'b0;
            end
            if (eng_ev.ack_fail) begin
               d.sec.ack_failure_flag = 1'b1;
            end
            if (eng_ev.start_sent) begin
               d.sb         = 1'b1;
               d.master     = 1'b1;
               d.ctrl.start = 1'b0;
            end
            if (eng_ev.stop_sent) begin
               d.ctrl.stop = 1'b0;
            end
            if (eng_ev.addr_sent) begin
               d.post_addr = 1'b1;
            end
            if (eng_ev.byte_done) begin
               d.byte_done_flag = 1'b1;
               d.transmitted_flag = eng_ev.byte_tx;
            end
            if (eng_ev.addr_rx && q.ctrl.ack_enable && (match_own || match_gc)) begin
               d.addr_matched_flag = 1'b1;
               if (match_gc) begin
                  d.sec.general_call_flag = 1'b1;
               end
            end
            // slave stop: let go of both lines once the byte is finished
            if (q.ctrl.stop && !q.master && q.byte_done_flag) begin
               d.release_l = 1'b1;
               d.byte_done_flag       = 1'b0;
               d.transmitted_flag       = 1'b0;
            end
         end
         // ---- disable wins over everything except stop and busy
         if (!d.ctrl.periph_enable) begin
            d.ctrl.general_call_enable = 1'b0;
            d.ctrl.start               = 1'b0;
            d.ctrl.ack_enable          = 1'b0;
            d.ctrl.irq_enable          = 1'b0;
            d.sec                      = '0;
            d.transmitted_flag                      = 1'b0;
            d.byte_done_flag                      = 1'b0;
            d.addr_matched_flag                     = 1'b0;
            d.master                   = 1'b0;
            d.sb                       = 1'b0;
            d.post_addr                = 1'b0;
            d.sr1_seen                 = 1'b0;
            d.release_l                = 1'b0;
         end
         d.event_flag = d.sb | d.byte_done_flag | d.addr_matched_flag | d.post_addr | d.sec.ack_failure_flag | d.sec.stop_seen_flag
               | d.sec.arb_lost_flag | d.sec.bus_error_flag;
      end
      // ---- registered pin and engine outputs
      stretch      = d.sb | d.byte_done_flag | d.addr_matched_flag | d.post_addr;
      drive_ok     = d.ctrl.periph_enable & ~cpu_halt & ~d.release_l;
      d.scl_oe_n   = ~(drive_ok & (stretch | eng_scl_low));
      d.sda_oe_n   = ~(drive_ok & eng_sda_low);
      d.ack_en     = d.ctrl.ack_enable & drive_ok;
      d.gc_en      = d.ctrl.general_call_enable & drive_ok;
      d.start_req  = d.ctrl.start & drive_ok & (d.master | ~d.busy);
      d.stop_req   = d.ctrl.stop & d.master & drive_ok;
      d.claimed    = d.ctrl.periph_enable;
      // wait mode leaves the block running; the wake request ignores the cpu mask
      d.wake       = d.event_flag & d.ctrl.irq_enable;
      d.irq        = d.event_flag & d.ctrl.irq_enable & ~cpu_gmask;
   end

   // ==========================================
   // registers
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         q          <= '0;
         q.scl_m1   <= 1'b1;
         q.scl_m2   <= 1'b1;
         q.scl_p    <= 1'b1;
         q.sda_m1   <= 1'b1;
         q.sda_m2   <= 1'b1;
         q.sda_p    <= 1'b1;
         q.scl_oe_n <= 1'b1;
         q.sda_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // outputs, all straight from flops
   assign reg_rdata    = q.rdata;
   assign irq          = q.irq;
   assign wake_req     = q.wake;
   // open-drain: the data value is a constant low, tx_load ANDed with zero
   assign scl_o        = q.tx_load & 1'b0;
   assign sda_o        = q.tx_load & 1'b0;
   assign scl_oe_n     = q.scl_oe_n;
   assign sda_oe_n     = q.sda_oe_n;
   assign start_req    = q.start_req;
   assign stop_req     = q.stop_req;
   assign ack_en       = q.ack_en;
   assign gc_en        = q.gc_en;
   assign pins_claimed = q.claimed;
   assign tx_data      = q.tx_data;
   assign tx_load      = q.tx_load;
endmodule
`default_nettype wire

// file: bench/i2cc_peer.sv
/*
 far side of the bus: another master that makes frames on scl and sda.
 assumes pull-ups on both lines and a dut that pulls a line low while its enable is low.
*/
`default_nettype none
module i2cc_peer (
   input  wire logic scl_oe_n,
   input  wire logic sda_oe_n,
   output logic      scl_i,
   output logic      sda_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // wired-and with pull-up
   logic pscl = 1'b1;
   logic psda = 1'b1;
   assign scl_i = pscl & scl_oe_n;
   assign sda_i = psda & sda_oe_n;
   // ==========================================
   // frames at a 160 ns bit time; scl stands high between frames
   task automatic frame(input logic [7:0] b);
      psda = 1'b0;
      #80;
      for (int i = 7; i >= 0; i--) begin
         pscl = 1'b0;
         psda = b[i];
         #80 pscl = 1'b1;
         #80;
      end
   endtask
   task automatic stop_cond();
      pscl = 1'b0;
      psda = 1'b0;
      #80 pscl = 1'b1;
      #80 psda = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// file: bench/i2cc_ctrl_chk.sv
/*
 concurrent checks on the ports of i2cc_ctrl.
 assumes one clock domain and a register port that never waits.
*/
`default_nettype none
module i2cc_ctrl_chk
   import i2cc_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input wire logic              ref_clk,
   input wire logic              resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   input wire logic              cpu_halt,
   input wire logic              cpu_gmask,
   input wire logic              irq,
   input wire logic              wake_req,
   input wire logic              scl_oe_n,
   input wire logic              sda_oe_n,
   input wire logic              start_req,
   input wire logic              ack_en,
   input wire logic              gc_en,
   input wire logic              pins_claimed,
   input wire logic [7:0]        tx_data,
   input wire logic              tx_load
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // helpers
   logic wr_c;
   logic live;
   assign wr_c = reg_wr && !cpu_halt && (reg_addr == ADDR_W'(OFS_CTRL));
   assign live = reg_rd && !cpu_halt;
   // ==========================================
   // assertions
   AST_IRQ: assert property (!cpu_halt && !$past(cpu_halt) |-> irq == (wake_req && !$past(cpu_gmask)))
      else $error("irq does not follow event and mask");
   AST_REL: assert property (!pins_claimed |-> scl_oe_n && sda_oe_n && !irq && !start_req && !ack_en && !gc_en)
      else $error("outputs not released while disabled");
   AST_HALT_REL: assert property (cpu_halt |=> scl_oe_n && sda_oe_n)
      else $error("lines driven in halt");
   AST_FROZEN: assert property ($past(cpu_halt) |-> $stable(reg_rdata) && $stable(pins_claimed))
      else $error("state moved in halt");
   AST_TXLOAD: assert property (reg_wr && !cpu_halt && pins_claimed && reg_addr == ADDR_W'(OFS_DATA)
      |=> tx_load && tx_data == $past(reg_wdata))
      else $error("data write not loaded");
   AST_RSV_CR: assert property (live && reg_addr == ADDR_W'(OFS_CTRL) |=> reg_rdata[7:6] == 2'b00)
      else $error("control reserved bits set");
   AST_RSV_SR: assert property (live && reg_addr == ADDR_W'(OFS_PRI) |=> !reg_rdata[6])
      else $error("status reserved bit set");
   AST_FIRST: assert property (wr_c && !pins_claimed |=> pins_claimed == $past(reg_wdata[CR_PE])
      && !ack_en && !gc_en && !start_req)
      else $error("first enabling write set more than enable");
   AST_ACK: assert property (wr_c && pins_claimed && reg_wdata[CR_PE] |=> ack_en == $past(reg_wdata[CR_ACK])
      && gc_en == $past(reg_wdata[CR_GC]))
      else $error("ack or general call enable wrong");
   // ==========================================
   // covers
   cover property (tx_load);
   cover property (irq);
   cover property (!scl_oe_n);
   cover property (cpu_halt && pins_claimed);
endmodule
bind i2cc_ctrl i2cc_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_halt(cpu_halt),
   .cpu_gmask(cpu_gmask), .irq(irq), .wake_req(wake_req), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
   .start_req(start_req), .ack_en(ack_en), .gc_en(gc_en), .pins_claimed(pins_claimed), .tx_data(tx_data),
   .tx_load(tx_load));
`default_nettype wire

// file: bench/i2cc_ctrl_bench.sv
/*
 bench of i2cc_ctrl: a table of engine events, then hand-written cases.
 assumes the bench plays the bus engine and the peer model plays the bus.
*/
`default_nettype none
module i2cc_ctrl_bench
   import i2cc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // signals
   logic       ref_clk = 1'b0;
   logic       resetn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       cpu_halt = 1'b0;
   logic       cpu_gmask = 1'b0;
   i2cc_ev_s   eng_ev = '0;
   logic [7:0] eng_addr_byte = 8'h00;
   logic       eng_byte_active = 1'b0;
   logic       stop_req;
   logic [7:0] reg_rdata, tx_data;
   logic       irq, wake_req, start_req, ack_en, gc_en, pins_claimed, tx_load;
   logic       scl_i, sda_i, scl_oe_n, sda_oe_n;
   int         n_mismatch = 0;
   int         compares = 0;
   always #10 ref_clk = ~ref_clk;
   i2cc_peer i_peer (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_i(scl_i), .sda_i(sda_i));
   i2cc_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_halt(cpu_halt), .cpu_gmask(cpu_gmask),
      .irq(irq), .wake_req(wake_req), .scl_i(scl_i), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(),
      .sda_oe_n(sda_oe_n), .eng_ev(eng_ev), .eng_addr_byte(eng_addr_byte), .eng_rx_data(8'h5a),
      .eng_byte_active(eng_byte_active), .eng_scl_low(1'b0), .eng_sda_low(1'b0), .own_addr(8'h42),
      .start_req(start_req), .stop_req(stop_req), .ack_en(ack_en), .gc_en(gc_en), .pins_claimed(pins_claimed),
      .tx_data(tx_data), .tx_load(tx_load));
   // ==========================================
   // table: event, address byte, primary, secondary, scl held
   typedef struct packed {
      logic [7:0] ev;
      logic [7:0] ab;
      logic [7:0] pri;
      logic [7:0] sec;
      logic       held;
   } i2cc_row_s;
   localparam i2cc_row_s ROWS [10] = '{
      '{8'hc0, 8'h00, 8'ha8, 8'h00, 1'b1},
      '{8'h80, 8'h00, 8'h88, 8'h00, 1'b1},
      '{8'h20, 8'h42, 8'h84, 8'h00, 1'b1},
      '{8'h20, 8'h43, 8'h84, 8'h00, 1'b1},
      '{8'h20, 8'h00, 8'h84, 8'h01, 1'b1},
      '{8'h20, 8'h01, 8'h00, 8'h00, 1'b0},
      '{8'h10, 8'h00, 8'h83, 8'h00, 1'b1},
      '{8'h04, 8'h00, 8'h80, 8'h00, 1'b1},
      '{8'h02, 8'h00, 8'h80, 8'h10, 1'b0},
      '{8'h01, 8'h00, 8'h80, 8'h04, 1'b0}
   };
   // ==========================================
   // tasks
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask
   task automatic en(input logic [7:0] c);
      wr(OFS_CTRL, c);
      wr(OFS_CTRL, c);
   endtask
   task automatic pulse(input logic [7:0] ev, input logic [7:0] ab);
      @(posedge ref_clk);
      eng_ev <= i2cc_ev_s'(ev);
      eng_addr_byte <= ab;
      @(posedge ref_clk);
      eng_ev <= '0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // watchdog: the whole run needs well under 2000 cycles
   initial begin
      #100us;
      n_mismatch++;
      finish_test();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      foreach (ROWS[i]) begin
         en(8'h35);
         pulse(ROWS[i].ev, ROWS[i].ab);
         chk("irq", {7'h0, ROWS[i].pri[7]}, {7'h0, irq});
         chk("scl held", {7'h0, ROWS[i].held}, {7'h0, ~scl_oe_n});
         rd(OFS_PRI, ROWS[i].pri, "primary");
         rd(OFS_SEC, ROWS[i].sec, "secondary");
         wr(OFS_CTRL, 8'h00);
         rd(OFS_PRI, 8'h00, "primary off");
         $display("row %0d done", i);
      end
      wr(OFS_CTRL, 8'hf5);
      rd(OFS_CTRL, 8'h20, "first enable");
      wr(OFS_CTRL, 8'hf5);
      rd(OFS_CTRL, 8'h35, "second write");
      rd(OFS_DATA, 8'h5a, "rx data");
      pulse(8'hc0, 8'h00);
      chk("scl wire", 8'h00, {7'h0, scl_i});
      wr(OFS_DATA, 8'h55);
      rd(OFS_PRI, 8'ha8, "no read first");
      wr(OFS_DATA, 8'h66);
      chk("tx data", 8'h66, tx_data);
      rd(OFS_PRI, 8'h00, "tx cleared");
      chk("scl free", 8'h01, {7'h0, scl_oe_n});
      pulse(8'h80, 8'h00);
      rd(OFS_PRI, 8'h88, "rx done");
      rd(OFS_DATA, 8'h5a, "rx data");
      rd(OFS_PRI, 8'h00, "rx cleared");
      pulse(8'h04, 8'h00);
      rd(OFS_PRI, 8'h80, "post address");
      wr(OFS_CTRL, 8'h35);
      rd(OFS_PRI, 8'h00, "post address cleared");
      $display("pairing test done");
      cpu_gmask <= 1'b1;
      pulse(8'h80, 8'h00);
      chk("masked irq", 8'h00, {7'h0, irq});
      chk("wake", 8'h01, {7'h0, wake_req});
      cpu_gmask <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk("unmasked irq", 8'h01, {7'h0, irq});
      wr(OFS_CTRL, 8'h34);
      repeat (1) @(posedge ref_clk);
      #1 chk("wake off", 8'h00, {7'h0, wake_req});
      wr(OFS_CTRL, 8'h00);
      $display("mask test done");
      en(8'h35);
      wr(OFS_CTRL, 8'h3d);
      rd(OFS_PRI, 8'h02, "master");
      chk("start req", 8'h01, {7'h0, start_req});
      pulse(8'h10, 8'h00);
      rd(OFS_CTRL, 8'h35, "start cleared");
      rd(OFS_PRI, 8'h83, "start sent");
      wr(OFS_CTRL, 8'h22);
      chk("stop req", 8'h01, {7'h0, stop_req});
      pulse(8'h08, 8'h00);
      rd(OFS_CTRL, 8'h20, "stop sent");
      wr(OFS_CTRL, 8'h02);
      rd(OFS_CTRL, 8'h02, "stop kept");
      wr(OFS_CTRL, 8'h00);
      $display("start stop test done");
      en(8'h35);
      cpu_halt <= 1'b1;
      pulse(8'h80, 8'h00);
      wr(OFS_CTRL, 8'h00);
      cpu_halt <= 1'b0;
      rd(OFS_CTRL, 8'h35, "halt ctrl");
      rd(OFS_PRI, 8'h00, "halt status");
      wr(OFS_CTRL, 8'h00);
      i_peer.frame(8'ha0);
      rd(OFS_PRI, 8'h10, "busy");
      i_peer.stop_cond();
      rd(OFS_PRI, 8'h00, "idle");
      en(8'h35);
      eng_byte_active <= 1'b1;
      i_peer.frame(8'ha0);
      rd(OFS_PRI, 8'h90, "bus error start");
      rd(OFS_SEC, 8'h02, "bus error");
      i_peer.stop_cond();
      rd(OFS_SEC, 8'h0a, "stop seen");
      eng_byte_active <= 1'b0;
      rd(OFS_PRI, 8'h00, "errors cleared");
      wr(OFS_CTRL, 8'h00);
      $display("halt and busy test done");
      en(8'h35);
      pulse(8'h80, 8'h00);
      resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(OFS_CTRL, 8'h00, "reset ctrl");
      rd(OFS_PRI, 8'h00, "reset primary");
      rd(OFS_SEC, 8'h00, "reset secondary");
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00, "unmapped");
      $display("reset test done");
      finish_test();
   end
endmodule
`default_nettype wire
